// ### src/iefp_top.v
// interrupt enable, factor flag and priority register bank behind an apb slave
`timescale 1ns/100ps
`include "iefp_map.vh"
module iefp_top #(
	parameter ADDR_W = `IEFP_ADDR_W,
	parameter DATA_W = `IEFP_DATA_W
) (
	// clock and reset
	input  wire                       mclk,
	input  wire                       reset_n,
	// apb slave
	input  wire                       psel,
	input  wire                       penable,
	input  wire                       pwrite,
	input  wire [ADDR_W-1:0]          paddr,
	input  wire [DATA_W-1:0]          pwdata,
	input  wire [3:0]                 pstrb,
	output wire                       pready,
	output reg  [DATA_W-1:0]          prdata,
	output reg                        pslverr,
	// factor sources, one-cycle pulses
	input  wire [`IEFP_TB_COUNT-1:0]  timebase_event,
	input  wire [`IEFP_SRC_COUNT-1:0] source_event,
	input  wire                       converter_event,
	input  wire                       melody_event,
	// requests toward the cpu
	output reg  [`IEFP_SRC_COUNT-1:0] source_irq_req,
	output reg                        converter_irq_req,
	output reg                        melody_irq_req,
	output reg  [`IEFP_TB_COUNT-1:0]  timebase_factor,
	// priority levels
	output reg  [1:0]                 converter_priority,
	output reg  [1:0]                 melody_priority
);
	// register state
	reg  [`IEFP_SRC_COUNT-1:0] source_enable;
	reg  [1:0]                 conv_prio;
	reg  [1:0]                 mel_prio;
	reg                        converter_irq_enable;
	reg                        melody_irq_enable;
	wire [`IEFP_TB_COUNT-1:0]  tb_flags;
	wire [`IEFP_SRC_COUNT-1:0] src_flags;
	wire [`IEFP_CM_COUNT-1:0]  cm_flags;

	// named views of the source enables and flags
	wire timer_one_irq_enable        = source_enable[`IEFP_SRC_TIMER_ONE];
	wire timer_zero_irq_enable       = source_enable[`IEFP_SRC_TIMER_ZERO];
	wire single_line_irq_enable      = source_enable[`IEFP_SRC_SINGLE_LINE];
	wire upper_group_irq_enable      = source_enable[`IEFP_SRC_UPPER_GROUP];
	wire lower_group_irq_enable      = source_enable[`IEFP_SRC_LOWER_GROUP];
	wire serial_error_irq_enable     = source_enable[`IEFP_SRC_SERIAL_ERROR];
	wire serial_receive_irq_enable   = source_enable[`IEFP_SRC_SERIAL_RECEIVE];
	wire serial_transmit_irq_enable  = source_enable[`IEFP_SRC_SERIAL_TRANSMIT];
	wire timer_one_factor_flag       = src_flags[`IEFP_SRC_TIMER_ONE];
	wire timer_zero_factor_flag      = src_flags[`IEFP_SRC_TIMER_ZERO];
	wire single_line_factor_flag     = src_flags[`IEFP_SRC_SINGLE_LINE];
	wire upper_group_factor_flag     = src_flags[`IEFP_SRC_UPPER_GROUP];
	wire lower_group_factor_flag     = src_flags[`IEFP_SRC_LOWER_GROUP];
	wire serial_error_factor_flag    = src_flags[`IEFP_SRC_SERIAL_ERROR];
	wire serial_receive_factor_flag  = src_flags[`IEFP_SRC_SERIAL_RECEIVE];
	wire serial_transmit_factor_flag = src_flags[`IEFP_SRC_SERIAL_TRANSMIT];
	wire converter_factor_flag       = cm_flags[1];
	wire melody_factor_flag          = cm_flags[0];

	// apb phases
	wire setup_phase  = psel && !penable;
	wire access_phase = psel && penable;
	wire lane0        = pstrb[0];

	// zero wait states; read data was captured at the setup edge
	assign pready = 1'b1;

	// address decode
	wire hit_src_en    = (paddr == `IEFP_ADR_SRC_EN);
	wire hit_tb_flags  = (paddr == `IEFP_ADR_TB_FLAGS);
	wire hit_src_flags = (paddr == `IEFP_ADR_SRC_FLAGS);
	wire hit_cm_prio   = (paddr == `IEFP_ADR_CM_PRIO);
	wire hit_cm_en     = (paddr == `IEFP_ADR_CM_EN);
	wire hit_cm_flags  = (paddr == `IEFP_ADR_CM_FLAGS);
	wire hit_any       = hit_src_en | hit_tb_flags | hit_src_flags |
	                     hit_cm_prio | hit_cm_en | hit_cm_flags;

	// a write takes effect only on the completing access edge, low lane strobed
	wire wr_commit = access_phase && pwrite && lane0;
	wire wr_src_en    = wr_commit && hit_src_en;
	wire wr_tb_flags  = wr_commit && hit_tb_flags;
	wire wr_src_flags = wr_commit && hit_src_flags;
	wire wr_cm_prio   = wr_commit && hit_cm_prio;
	wire wr_cm_en     = wr_commit && hit_cm_en;
	wire wr_cm_flags  = wr_commit && hit_cm_flags;

	// write data fields; only the low byte carries anything
	wire [`IEFP_SRC_COUNT-1:0] next_source_enable;
	wire [1:0]                 next_conv_prio;
	wire [1:0]                 next_mel_prio;
	wire                       next_conv_enable;
	wire                       next_mel_enable;
	wire [`IEFP_TB_COUNT-1:0]  tb_clear_mask;
	wire [`IEFP_SRC_COUNT-1:0] src_clear_mask;
	wire [`IEFP_CM_COUNT-1:0]  cm_clear_mask;
	assign next_source_enable = pwdata[`IEFP_SRC_COUNT-1:0];
	assign next_conv_prio     = pwdata[`IEFP_CONV_PRIO_HI:`IEFP_CONV_PRIO_LO];
	assign next_mel_prio      = pwdata[`IEFP_MEL_PRIO_HI:`IEFP_MEL_PRIO_LO];
	assign next_conv_enable   = pwdata[`IEFP_CONV_BIT];
	assign next_mel_enable    = pwdata[`IEFP_MEL_BIT];
	assign tb_clear_mask      = pwdata[`IEFP_TB_COUNT-1:0];
	assign src_clear_mask     = pwdata[`IEFP_SRC_COUNT-1:0];
	assign cm_clear_mask      = pwdata[`IEFP_CONV_BIT:`IEFP_MEL_BIT];

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			source_enable <= `IEFP_RST_SRC_EN;
		end else if (wr_src_en) begin
			source_enable <= next_source_enable;
		end
	end

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			conv_prio <= `IEFP_RST_PRIO;
		end else if (wr_cm_prio) begin
			conv_prio <= next_conv_prio;
		end
	end

	// low bits of the word dropped
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			mel_prio <= `IEFP_RST_PRIO;
		end else if (wr_cm_prio) begin
			mel_prio <= next_mel_prio;
		end
	end

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			converter_irq_enable <= 1'b0;
		end else if (wr_cm_en) begin
			converter_irq_enable <= next_conv_enable;
		end
	end

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			melody_irq_enable <= 1'b0;
		end else if (wr_cm_en) begin
			melody_irq_enable <= next_mel_enable;
		end
	end

	// timebase flags, seven wide so bit 7 has no storage
	iefp_flag_bank #(
		.WIDTH(`IEFP_TB_COUNT)
	) u_tb_flags (
		.mclk        (mclk),
		.reset_n     (reset_n),
		.set_pulse   (timebase_event),
		.clear_strobe(wr_tb_flags),
		.clear_mask  (tb_clear_mask),
		.flags       (tb_flags)
	);

	iefp_flag_bank #(
		.WIDTH(`IEFP_SRC_COUNT)
	) u_src_flags (
		.mclk        (mclk),
		.reset_n     (reset_n),
		.set_pulse   (source_event),
		.clear_strobe(wr_src_flags),
		.clear_mask  (src_clear_mask),
		.flags       (src_flags)
	);

	iefp_flag_bank #(
		.WIDTH(`IEFP_CM_COUNT)
	) u_cm_flags (
		.mclk        (mclk),
		.reset_n     (reset_n),
		.set_pulse   ({converter_event, melody_event}),
		.clear_strobe(wr_cm_flags),
		.clear_mask  (cm_clear_mask),
		.flags       (cm_flags)
	);

	// read mux
	reg [`IEFP_REG_W-1:0] next_read;
	always @* begin
		next_read = 8'h00;
		case (1'b1)
			hit_src_en: begin
				next_read = {timer_one_irq_enable, timer_zero_irq_enable,
				             single_line_irq_enable, upper_group_irq_enable,
				             lower_group_irq_enable, serial_error_irq_enable,
				             serial_receive_irq_enable, serial_transmit_irq_enable};
			end
			hit_tb_flags: begin
				next_read = {1'b0, tb_flags};
			end
			hit_src_flags: begin
				next_read = {timer_one_factor_flag, timer_zero_factor_flag,
				             single_line_factor_flag, upper_group_factor_flag,
				             lower_group_factor_flag, serial_error_factor_flag,
				             serial_receive_factor_flag, serial_transmit_factor_flag};
			end
			hit_cm_prio: begin
				next_read = {conv_prio, mel_prio, 4'h0};
			end
			hit_cm_en: begin
				next_read = {converter_irq_enable, melody_irq_enable, 6'h00};
			end
			hit_cm_flags: begin
				next_read = {converter_factor_flag, melody_factor_flag, 6'h00};
			end
			default: begin
				next_read = 8'h00;
			end
		endcase
	end

	// read data captured at the setup edge so it stands through access;
	// the trade: a flag set during the access cycle shows on the next read
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			prdata <= 32'h00000000;
		end else if (setup_phase) begin
			// writes read back zero
			prdata <= pwrite ? 32'h00000000 : {24'h000000, next_read};
		end
	end

	// unmapped offsets answer with an error, zero data and no write
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pslverr <= 1'b0;
		end else if (setup_phase) begin
			pslverr <= !hit_any;
		end
	end

	wire [`IEFP_SRC_COUNT-1:0] next_source_irq_req;
	wire                       next_converter_irq_req;
	wire                       next_melody_irq_req;
	genvar s;
	generate
		for (s = 0; s < `IEFP_SRC_COUNT; s = s + 1) begin : g_src_req
			assign next_source_irq_req[s] = src_flags[s] & source_enable[s];
		end
	endgenerate
	// converter and melody requests gated alike
	assign next_converter_irq_req = converter_factor_flag & converter_irq_enable;
	assign next_melody_irq_req    = melody_factor_flag & melody_irq_enable;

	// requests come from flops: one cycle of latency bought for clean outputs
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			source_irq_req <= 8'h00;
		end else begin
			source_irq_req <= next_source_irq_req;
		end
	end

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			converter_irq_req <= 1'b0;
		end else begin
			converter_irq_req <= next_converter_irq_req;
		end
	end

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			melody_irq_req <= 1'b0;
		end else begin
			melody_irq_req <= next_melody_irq_req;
		end
	end

	// timebase flags leave raw; their enables live outside this bank
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			timebase_factor <= 7'h00;
		end else begin
			timebase_factor <= tb_flags;
		end
	end

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			converter_priority <= 2'h0;
		end else begin
			converter_priority <= conv_prio;
		end
	end

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			melody_priority <= 2'h0;
		end else begin
			melody_priority <= mel_prio;
		end
	end
endmodule

// ### src/iefp_map.vh
// register indices, byte addresses, field positions and reset values of the bank
`ifndef IEFP_MAP_VH
`define IEFP_MAP_VH

`define IEFP_ADDR_W              20
`define IEFP_DATA_W              32
`define IEFP_REG_W               8

`define IEFP_IDX_SRC_EN          20'hFF23
`define IEFP_IDX_TB_FLAGS        20'hFF24
`define IEFP_IDX_SRC_FLAGS       20'hFF25
`define IEFP_IDX_CM_PRIO         20'hFF28
`define IEFP_IDX_CM_EN           20'hFF2A
`define IEFP_IDX_CM_FLAGS        20'hFF2C

`define IEFP_ADR_SRC_EN          20'h3FC8C
`define IEFP_ADR_TB_FLAGS        20'h3FC90
`define IEFP_ADR_SRC_FLAGS       20'h3FC94
`define IEFP_ADR_CM_PRIO         20'h3FCA0
`define IEFP_ADR_CM_EN           20'h3FCA8
`define IEFP_ADR_CM_FLAGS        20'h3FCB0

`define IEFP_SRC_TIMER_ONE       7
`define IEFP_SRC_TIMER_ZERO      6
`define IEFP_SRC_SINGLE_LINE     5
`define IEFP_SRC_UPPER_GROUP     4
`define IEFP_SRC_LOWER_GROUP     3
`define IEFP_SRC_SERIAL_ERROR    2
`define IEFP_SRC_SERIAL_RECEIVE  1
`define IEFP_SRC_SERIAL_TRANSMIT 0
`define IEFP_SRC_COUNT           8

`define IEFP_TB_SW_HUNDRED       6
`define IEFP_TB_SW_TEN           5
`define IEFP_TB_SW_ONE           4
`define IEFP_TB_CT_32HZ          3
`define IEFP_TB_CT_8HZ           2
`define IEFP_TB_CT_2HZ           1
`define IEFP_TB_CT_1HZ           0
`define IEFP_TB_COUNT            7

`define IEFP_CONV_PRIO_HI        7
`define IEFP_CONV_PRIO_LO        6
`define IEFP_MEL_PRIO_HI         5
`define IEFP_MEL_PRIO_LO         4
`define IEFP_CONV_BIT            7
`define IEFP_MEL_BIT             6
`define IEFP_CM_COUNT            2

`define IEFP_RST_SRC_EN          8'h00
`define IEFP_RST_TB_FLAGS        7'h00
`define IEFP_RST_SRC_FLAGS       8'h00
`define IEFP_RST_PRIO            2'h0
`define IEFP_RST_CM_EN           2'h0
`define IEFP_RST_CM_FLAGS        2'h0

`endif

// ### src/iefp_flag_bank.v
// bank of sticky factor flags, set by source pulses, cleared by writing one
`timescale 1ns/100ps
module iefp_flag_bank #(
	parameter WIDTH = 8
) (
	// clock and reset
	input  wire             mclk,
	input  wire             reset_n,
	// source events
	input  wire [WIDTH-1:0] set_pulse,
	// software clear
	input  wire             clear_strobe,
	input  wire [WIDTH-1:0] clear_mask,
	// flag state
	output wire [WIDTH-1:0] flags
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_flag
			// each bit owns its flop so no vector has several drivers
			reg flag;
			always @(posedge mclk or negedge reset_n) begin
				if (!reset_n) begin
					flag <= 1'b0;
				// source sets flag; set beats a clear in the same cycle
				end else if (set_pulse[i]) begin
					flag <= 1'b1;
				end else if (clear_strobe && clear_mask[i]) begin
					flag <= 1'b0;
				end
			end
			assign flags[i] = flag;
		end
	endgenerate
endmodule

// ### sim/iefp_src_model.sv
// behavioural model of the peripheral event sources
`timescale 1ns/100ps
module iefp_src_model (
	// clock and reset
	input  wire        mclk,
	input  wire        reset_n,
	// bench request, one bit per source
	input  wire [16:0] fire,
	// one-cycle factor pulses
	output reg  [6:0]  timebase_event,
	output reg  [7:0]  source_event,
	output reg         converter_event,
	output reg         melody_event
);
	reg [16:0] fire_q;
	// one pulse each
	// edge detect so a held request raises one factor only
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			fire_q <= 17'h00000;
			{converter_event, melody_event, source_event, timebase_event} <= 17'h00000;
		end else begin
			fire_q <= fire;
			{converter_event, melody_event, source_event, timebase_event} <= fire & ~fire_q;
		end
	end
endmodule

// ### sim/iefp_top_assertions.sv
// assertions on the register bank ports
`timescale 1ns/100ps
`include "iefp_map.vh"
module iefp_top_assertions #(
	parameter ADDR_W = 20,
	parameter DATA_W = 32
) (
	// clock and reset
	input wire              mclk,
	input wire              reset_n,
	// apb
	input wire              psel,
	input wire              penable,
	input wire              pwrite,
	input wire [ADDR_W-1:0] paddr,
	input wire [DATA_W-1:0] pwdata,
	input wire [DATA_W-1:0] prdata,
	input wire              pslverr,
	// events and requests
	input wire [6:0]        timebase_event,
	input wire [7:0]        source_event,
	input wire [6:0]        timebase_factor,
	input wire [7:0]        source_irq_req,
	input wire [1:0]        converter_priority,
	input wire [1:0]        melody_priority
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	wire acc = psel && penable;
	wire wr  = acc && pwrite;
	wire wtb = wr && paddr == `IEFP_ADR_TB_FLAGS;
	wire wsf = wr && paddr == `IEFP_ADR_SRC_FLAGS;
	wire wen = wr && paddr == `IEFP_ADR_SRC_EN;
	wire wpr = wr && paddr == `IEFP_ADR_CM_PRIO;
	wire hit = wtb || wsf || wen || wpr || paddr == `IEFP_ADR_CM_EN
		|| paddr == `IEFP_ADR_CM_FLAGS || paddr == `IEFP_ADR_TB_FLAGS
		|| paddr == `IEFP_ADR_SRC_FLAGS || paddr == `IEFP_ADR_SRC_EN
		|| paddr == `IEFP_ADR_CM_PRIO;
	property p_upper; acc |-> prdata[31:8] == 24'h000000; endproperty
	a_upper: assert property (p_upper) else $error("upper read bits set");
	property p_slverr; psel && !penable && !hit |=> pslverr && prdata == 0; endproperty
	a_slverr: assert property (p_slverr) else $error("unmapped access not refused");
	property p_tb_set;
		timebase_event != 0 |-> ##2
			(timebase_factor & $past(timebase_event, 2)) == $past(timebase_event, 2);
	endproperty
	a_tb_set: assert property (p_tb_set) else $error("timebase flag not set");
	property p_tb_rise; (timebase_factor & ~$past(timebase_factor)
		& ~$past(timebase_event, 2)) == 0; endproperty
	a_tb_rise: assert property (p_tb_rise) else $error("flag rose without event");
	property p_tb_clear; (~timebase_factor & $past(timebase_factor)) != 0
		|-> $past(wtb, 2); endproperty
	a_tb_clear: assert property (p_tb_clear) else $error("flag fell without write");
	property p_irq_rise; (source_irq_req & ~$past(source_irq_req)) != 0
		|-> $past(source_event, 2) != 0 || $past(wen, 2); endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("request rose uncaused");
	property p_irq_fall; (~source_irq_req & $past(source_irq_req)) != 0
		|-> $past(wsf, 2) || $past(wen, 2); endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("request fell uncaused");
	property p_prio; $changed({converter_priority, melody_priority}) |-> $past(wpr, 2)
		&& {converter_priority, melody_priority} == $past(pwdata[7:4], 2); endproperty
	a_prio: assert property (p_prio) else $error("priority change wrong");
	c_clear: cover property (wtb);
	c_irq: cover property (source_irq_req != 0);
	c_unmapped: cover property (psel && !penable && !hit);
endmodule
bind iefp_top iefp_top_assertions #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk (.*);

// ### sim/tb.sv
// self-checking bench for the register bank
`timescale 1ns/100ps
`include "iefp_map.vh"
module tb;
	reg         mclk = 0;
	reg         reset_n = 0;
	reg         psel = 0;
	reg         penable = 0;
	reg         pwrite = 0;
	reg  [19:0] paddr = 0;
	reg  [31:0] pwdata = 0;
	reg  [3:0]  pstrb = 0;
	reg  [16:0] fire = 0;
	wire        pready, pslverr, cv_ev, ml_ev, cv_irq, ml_irq;
	wire [31:0] prdata;
	wire [6:0]  tb_ev, tb_fac;
	wire [7:0]  src_ev, src_irq;
	wire [1:0]  cv_pri, ml_pri;
	integer     seed = 73;
	integer     error_cnt = 0;
	integer     checks_done = 0;
	integer     i, k;
	reg  [31:0] rd, rv;
	reg         er;
	reg  [7:0]  en_s = 0, fl_s = 0;
	reg  [6:0]  fl_t = 0;
	reg  [1:0]  en_c = 0, fl_c = 0;
	reg  [3:0]  pri = 0;
	always #4 mclk = ~mclk;
	iefp_src_model src (.mclk(mclk), .reset_n(reset_n), .fire(fire), .timebase_event(tb_ev),
		.source_event(src_ev), .converter_event(cv_ev), .melody_event(ml_ev));
	iefp_top uut (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .timebase_event(tb_ev), .source_event(src_ev),
		.converter_event(cv_ev), .melody_event(ml_ev), .source_irq_req(src_irq),
		.converter_irq_req(cv_irq), .melody_irq_req(ml_irq), .timebase_factor(tb_fac),
		.converter_priority(cv_pri), .melody_priority(ml_pri));
	function [19:0] adr(input integer n);
		case (n)
			0: adr = `IEFP_ADR_SRC_EN;
			1: adr = `IEFP_ADR_TB_FLAGS;
			2: adr = `IEFP_ADR_SRC_FLAGS;
			3: adr = `IEFP_ADR_CM_PRIO;
			4: adr = `IEFP_ADR_CM_EN;
			5: adr = `IEFP_ADR_CM_FLAGS;
			default: adr = 20'h3FC98;
		endcase
	endfunction
	function [7:0] expv(input integer n);
		case (n)
			0: expv = en_s;
			1: expv = {1'b0, fl_t};
			2: expv = fl_s;
			3: expv = {pri, 4'h0};
			4: expv = {en_c, 6'h00};
			5: expv = {fl_c, 6'h00};
			default: expv = 8'h00;
		endcase
	endfunction
	task check(input string nm, input [31:0] seen, input [31:0] exp);
		checks_done = checks_done + 1;
		if (seen !== exp) begin
			error_cnt = error_cnt + 1;
			$display("mismatch %0s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task apb(input w, input integer n, input [31:0] d, input [3:0] s);
		integer t;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= adr(n);
		pwdata <= d;
		pstrb <= s;
		@(posedge mclk);
		penable <= 1'b1;
		t = 0;
		do begin
			@(posedge mclk);
			t = t + 1;
		end while (pready !== 1'b1 && t < 50);
		if (t == 50) error_cnt = error_cnt + 1;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (w && s[0]) case (n)
			0: en_s = d[7:0];
			1: fl_t = fl_t & ~d[6:0];
			2: fl_s = fl_s & ~d[7:0];
			3: pri = d[7:4];
			4: en_c = d[7:6];
			5: fl_c = fl_c & ~d[7:6];
		endcase
	endtask
	task rdchk(input integer n);
		apb(1'b0, n, 32'h0, 4'hF);
		check("rdata", rd, expv(n));
		check("slverr", er, n > 5);
	endtask
	task shoot(input [16:0] v);
		@(posedge mclk);
		fire <= v;
		@(posedge mclk);
		fire <= 17'h00000;
		fl_t = fl_t | v[6:0];
		fl_s = fl_s | v[14:7];
		fl_c = fl_c | v[16:15];
	endtask
	task outs;
		repeat (3) @(posedge mclk);
		check("src_irq", src_irq, fl_s & en_s);
		check("cm_irq", {cv_irq, ml_irq}, fl_c & en_c);
		check("tb_fac", tb_fac, fl_t);
		check("prio", {cv_pri, ml_pri}, pri);
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#100000;
		error_cnt = error_cnt + 1;
		finish_test;
	end
	initial begin
		repeat (20) @(posedge mclk);
		reset_n <= 1'b1;
		for (i = 0; i < 7; i = i + 1) rdchk(i);
		$display("test reset done");
		for (i = 0; i < 4; i = i + 1) begin
			apb(1'b1, 3, {24'h0, i[1:0], ~i[1:0], 4'hF}, 4'hF);
			outs;
			rdchk(3);
		end
		$display("test priority done");
		shoot(17'h1FFFF);
		for (i = 0; i < 14; i = i + 1) begin
			apb(1'b1, i % 7, i < 7 ? 32'h0 : 32'hFF, 4'hF);
			check("wr_err", er, i % 7 == 6);
			outs;
			rdchk(i % 7);
		end
		$display("test clear done");
		for (i = 0; i < 60; i = i + 1) begin
			rv = $random(seed);
			k = rv[22:20] % 6;
			case (i % 3)
				0: shoot(rv[16:0]);
				1: apb(1'b1, k, rv, {3'h7, rv[23] | rv[24]});
				default: rdchk(k);
			endcase
			outs;
		end
		$display("test random done");
		finish_test;
	end
endmodule
